// >>> hdl/mps_params.svh
// Constants for the multi-protocol serial unit: codes, depths and timing
`ifndef MPS_PARAMS_SVH
`define MPS_PARAMS_SVH

// ****************************************
// Structure
// ****************************************
`define MPS_UNITS        5
`define MPS_FIFO_DEPTH   8
`define MPS_MBOX_DEPTH   32
`define MPS_IRQ_W        10
`define MPS_PHASES       4

// ****************************************
// Variant codes (cfg.sub)
// ****************************************
`define MPS_SUB_STD      2'h0
`define MPS_SUB_LIN      2'h1
`define MPS_SUB_IRDA     2'h2
`define MPS_SUB_CARD     2'h3
`define MPS_SUB_SPULSE   2'h1
`define MPS_SUB_3WIRE    2'h2

// ****************************************
// Line constants
// ****************************************
`define MPS_LIN_SYNC     8'h55

// ****************************************
// Timing
// ****************************************
`define MPS_CLK_HZ       10000000
`define MPS_I2C_MAX_BPS  1000000
`define MPS_UART_MAX_BPS 1000000
`define MPS_LIN_MAX_BPS  20000
// Least bit time at the LIN limit, rounded up to whole cycles
`define MPS_LIN_MIN_BIT_CYC \
	((`MPS_CLK_HZ + `MPS_LIN_MAX_BPS - 1) / `MPS_LIN_MAX_BPS)
// Smallest divider setting that keeps LIN at or below its limit
`define MPS_LIN_MIN_DIV  (`MPS_LIN_MIN_BIT_CYC / `MPS_PHASES - 1)

`endif

// >>> hdl/mps_pkg.sv
// Types shared by the multi-protocol serial unit
package mps_pkg;

	// ****************************************
	// Modes and states
	// ****************************************
	typedef enum logic [1:0] {
		MPS_MODE_SPI  = 2'h0,
		MPS_MODE_I2C  = 2'h1,
		MPS_MODE_UART = 2'h2,
		MPS_MODE_LIN  = 2'h3
	} mps_mode_t;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_START = 6'h02,
		ST_DATA  = 6'h04,
		ST_PAR   = 6'h08,
		ST_STOP  = 6'h10,
		ST_ACK   = 6'h20
	} mps_state_t;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic        enable;
		mps_mode_t   mode;
		logic [1:0]  sub;
		logic        parity_en;
		logic        parity_odd;
		logic        nine_bit;
		logic        i2c_master;
		logic        mailbox_i2c_mode;
		logic [6:0]  own_addr;
		logic [15:0] clk_div;
	} mps_cfg_t;

	typedef struct packed {
		logic overflow;
		logic sync_err;
		logic done;
		logic nack;
		logic arb_lost;
		logic brk;
		logic frm_err;
		logic par_err;
	} mps_flags_t;

	// Registered control state of one unit; mailbox array and FIFOs are kept apart
	typedef struct packed {
		logic [15:0] div;
		logic [1:0]  ph;
		mps_state_t  txst;
		logic [3:0]  tcnt;
		logic [8:0]  tsh;
		logic        tpar;
		logic        tread;
		logic [15:0] rdiv;
		logic [1:0]  rph;
		mps_state_t  rxst;
		logic [3:0]  rcnt;
		logic [8:0]  rsh;
		logic        rpar;
		logic        rseen;
		logic        card_nack;
		logic [1:0]  lin;
		logic        scl_q;
		logic        sda_q;
		logic        sl_act;
		logic        sl_rw;
		logic        sl_addr;
		logic        sl_ptrset;
		logic        sl_oe;
		logic [3:0]  sl_cnt;
		logic [7:0]  sl_sh;
		logic [7:0]  sl_ptr;
		mps_flags_t  flags;
	} mps_unit_st_t;

endpackage

// >>> hdl/mps_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module mps_fifo #(
	parameter int W = 9,
	parameter int D = 8
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         flush,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;

	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0]   cnt;
	} mps_fifo_st_t;

	mps_fifo_st_t       s;
	mps_fifo_st_t       n;
	logic [W-1:0]       mem [D];
	logic               push;
	logic               pop;

	// Honest full and empty straight from the fill count
	assign in_ready  = (s.cnt != (AW+1)'(D));
	assign out_valid = (s.cnt != '0);
	assign out_data  = mem[s.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer wrap works for any depth, not only powers of two
	always_comb begin
		n = s;
		if (push) begin
			n.wr = (s.wr == AW'(D-1)) ? '0 : s.wr + AW'(1);
		end
		if (pop) begin
			n.rd = (s.rd == AW'(D-1)) ? '0 : s.rd + AW'(1);
		end
		n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (flush) begin
			n = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Storage is not reset; the count guards it
	always_ff @(posedge clk) begin
		if (push && !flush) begin
			mem[s.wr] <= in_data;
		end
	end

endmodule

// >>> hdl/mps_unit.sv
// Run-time selectable SPI / I2C / UART / LIN slave serial unit
//
// Notes on behaviour
// - Five identical units exist; each picks SPI, I2C, UART or LIN at run time.
// - I2C runs as master or slave; a master arbitrates against others.
// - I2C reaches 1 Mbps, standard mode to fast mode plus.
// - Mailbox I2C mode maps bus reads and writes onto a memory array.
// - I2C slave bytes outside mailbox mode pass through eight-deep receive and transmit FIFOs; a master uses only the transmit FIFO.
// - I2C clock and data lines only pull low or release.
// - UART line rates reach 1 Mbps.
// - UART also offers LIN, IrDA and smartcard framing variants.
// - Nine-bit multiprocessor mode marks address frames with the ninth bit.
// - UART receiver reports parity errors, breaks and framing errors.
// - UART data passes through eight-deep FIFOs.
// - SPI offers standard, start-pulse framed and half-duplex three-wire.
// - SPI data passes through the same FIFOs as other modes.
// - LIN slave mode handles break, sync and identifier of each frame.
// - LIN_RATE_ERR flags a divider that would run LIN above about 20 Kbps; nothing else limits it.
// - Unit timing comes from a programmable divider of the root clock.
`timescale 1ns/1ps
`include "mps_params.svh"
module mps_unit import mps_pkg::*; #(
	parameter int FIFO_DEPTH = `MPS_FIFO_DEPTH,
	parameter int MBOX_DEPTH = `MPS_MBOX_DEPTH
) (
	input  wire logic                  CLK,
	input  wire logic                  SRST,
	input  wire mps_cfg_t              CFG,
	input  wire mps_flags_t            CLR_FLAGS,
	input  wire logic [`MPS_IRQ_W-1:0] IRQ_EN,
	input  wire logic                  TX_VALID,
	input  wire logic [8:0]            TX_DATA,
	output logic                       TX_READY,
	output logic                       RX_VALID,
	output logic [8:0]                 RX_DATA,
	input  wire logic                  RX_READY,
	input  wire logic [7:0]            MBOX_ADDR,
	input  wire logic                  MBOX_WE,
	input  wire logic [7:0]            MBOX_WDATA,
	output logic [7:0]                 MBOX_RDATA,
	input  wire logic                  UART_RX,
	output logic                       UART_TX,
	input  wire logic                  SCL_I,
	output logic                       SCL_O,
	output logic                       SCL_OE,
	input  wire logic                  SDA_I,
	output logic                       SDA_O,
	output logic                       SDA_OE,
	output logic                       SPI_SCK,
	output logic                       SPI_SEL,
	input  wire logic                  SPI_MOSI_I,
	output logic                       SPI_MOSI_O,
	output logic                       SPI_MOSI_OE,
	input  wire logic                  SPI_MISO,
	output mps_flags_t                 FLAGS,
	output logic                       BUSY,
	output logic                       LIN_RATE_ERR,
	output logic                       IRQ
);
	localparam int PW = $clog2(MBOX_DEPTH);

	mps_unit_st_t s;
	mps_unit_st_t n;
	logic [7:0]   mbox [MBOX_DEPTH];
	logic         txq_v, txq_rdy, tx_pop;
	logic [8:0]   txq_d;
	logic         rxq_rdy, rx_push;
	logic [8:0]   rx_word;
	mps_flags_t   fset;
	logic         mb_we;
	logic [7:0]   mb_wd;
	logic         uart_m, spi_m, i2c_m, i2c_s, irda, card, w3;
	logic         hold, tick, bit_end, rtick, samp;
	logic         tx_bit, rx_line, spi_in, b;

	// ****************************************
	// Helpers
	// ****************************************
	// Bits per character: nine-bit mode adds the address marker
	function automatic logic [3:0] nbits(input logic nine);
		return nine ? 4'h9 : 4'h8;
	endfunction

	// Mailbox pointer wraps at the end of the mapped range
	function automatic logic [7:0] ptr_inc(input logic [7:0] p);
		return (p == 8'(MBOX_DEPTH-1)) ? 8'h00 : p + 8'h01;
	endfunction

	// ****************************************
	// FIFOs
	// ****************************************
	mps_fifo #(.W(9), .D(FIFO_DEPTH)) u_txq (
		.clk       (CLK),
		.srst      (SRST),
		.flush     (!CFG.enable),
		.in_valid  (TX_VALID),
		.in_data   (TX_DATA),
		.in_ready  (txq_rdy),
		.out_valid (txq_v),
		.out_data  (txq_d),
		.out_ready (tx_pop)
	);

	mps_fifo #(.W(9), .D(FIFO_DEPTH)) u_rxq (
		.clk       (CLK),
		.srst      (SRST),
		.flush     (!CFG.enable),
		.in_valid  (rx_push),
		.in_data   (rx_word),
		.in_ready  (rxq_rdy),
		.out_valid (RX_VALID),
		.out_data  (RX_DATA),
		.out_ready (RX_READY)
	);

	// ****************************************
	// Mode decode and timing enables
	// ****************************************
	// One unit of several; the mode field alone picks the protocol
	assign uart_m = CFG.enable && (CFG.mode == MPS_MODE_UART ||
		CFG.mode == MPS_MODE_LIN);
	assign spi_m  = CFG.enable && CFG.mode == MPS_MODE_SPI;
	assign i2c_m  = CFG.enable && CFG.mode == MPS_MODE_I2C &&
		CFG.i2c_master;
	assign i2c_s  = CFG.enable && CFG.mode == MPS_MODE_I2C &&
		!CFG.i2c_master;
	assign irda   = CFG.mode == MPS_MODE_UART && CFG.sub == `MPS_SUB_IRDA;
	assign card   = CFG.mode == MPS_MODE_UART && CFG.sub == `MPS_SUB_CARD;
	assign w3     = CFG.sub == `MPS_SUB_3WIRE;
	// A slave holding SCL low stretches the master's high phase
	assign hold    = i2c_m && s.txst != ST_IDLE && s.ph[1] && !SCL_I;
	// Four phase enables per bit; DIV=0 gives 2.5 Mbps at 10 MHz
	// No wrap wait when the divider is lowered
	assign tick    = (s.div >= CFG.clk_div);
	assign bit_end = tick && s.ph == 2'h3 && !hold;
	assign rtick   = (s.rdiv >= CFG.clk_div);
	assign samp    = rtick && s.rph == 2'h2;
	assign spi_in  = w3 ? SPI_MOSI_I : SPI_MISO;
	// IrDA marks a zero with a short high pulse anywhere in the bit
	assign rx_line = irda ? !(UART_RX || s.rseen) : UART_RX;
	assign b       = rx_line;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		n = s;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_word = '0;
		fset = '0;
		mb_we = 1'b0;
		mb_wd = '0;
		n.div = tick ? 16'h0000 : s.div + 16'h0001;
		n.ph = (tick && !hold) ? s.ph + 2'h1 : s.ph;
		n.rdiv = rtick ? 16'h0000 : s.rdiv + 16'h0001;
		n.rph = rtick ? s.rph + 2'h1 : s.rph;
		n.scl_q = SCL_I;
		n.sda_q = SDA_I;
		// Transmit engine shared by UART, SPI and I2C master
		case (s.txst)
			ST_IDLE: begin
				if (bit_end && txq_v && (uart_m || spi_m || i2c_m)) begin
					tx_pop = 1'b1;
					n.tsh = txq_d;
					n.tread = txq_d[8];
					n.tpar = 1'b0;
					n.tcnt = 4'h0;
					n.txst = ST_START;
				end
			end
			ST_START: begin
				if (bit_end) begin
					n.txst = ST_DATA;
				end
			end
			ST_DATA: begin
				if (i2c_m && tick && !hold && s.ph == 2'h2 &&
					s.tsh[7] && !SDA_I) begin
					n.txst = ST_IDLE;
					fset.arb_lost = 1'b1;
				end else if (bit_end) begin
					n.tcnt = s.tcnt + 4'h1;
					if (uart_m) begin
						n.tsh = {1'b0, s.tsh[8:1]};
						n.tpar = s.tpar ^ s.tsh[0];
					end else begin
						n.tsh = {s.tsh[7:0], spi_in};
					end
					if (uart_m && s.tcnt == nbits(CFG.nine_bit) - 4'h1) begin
						n.txst = (CFG.parity_en || card) ? ST_PAR : ST_STOP;
					end else if (!uart_m && s.tcnt == 4'h7) begin
						n.txst = i2c_m ? ST_ACK : ST_STOP;
					end
				end
			end
			ST_PAR: begin
				if (bit_end) begin
					n.txst = ST_STOP;
				end
			end
			ST_ACK: begin
				if (bit_end) begin
					if (SDA_I) begin
						fset.nack = 1'b1;
						n.txst = ST_STOP;
					end else if (txq_v) begin
						tx_pop = 1'b1;
						n.tsh = txq_d;
						n.tcnt = 4'h0;
						n.txst = txq_d[8] ? ST_START : ST_DATA;
					end else begin
						n.txst = ST_STOP;
					end
				end
			end
			ST_STOP: begin
				if (bit_end) begin
					n.txst = ST_IDLE;
					fset.done = 1'b1;
					if (spi_m && !(w3 && !s.tread)) begin
						rx_push = 1'b1;
						rx_word = {1'b0, s.tsh[7:0]};
					end
				end
			end
			default: n.txst = ST_IDLE;
		endcase
		// UART receive engine; sampling is re-aligned on each start edge
		if (irda) begin
			n.rseen = samp ? 1'b0 : (s.rseen || UART_RX);
		end
		case (s.rxst)
			ST_IDLE: begin
				if (uart_m && !b) begin
					n.rxst = ST_START;
					n.rdiv = 16'h0000;
					n.rph = 2'h1;
					n.rseen = UART_RX; // Keep IrDA start pulse
				end
			end
			ST_START: begin
				if (samp) begin
					n.rxst = b ? ST_IDLE : ST_DATA;
					n.rcnt = 4'h0;
					n.rsh = '0;
					n.rpar = 1'b0;
				end
			end
			ST_DATA: begin
				if (samp) begin
					n.rsh[s.rcnt] = b;
					n.rpar = s.rpar ^ b;
					n.rcnt = s.rcnt + 4'h1;
					if (s.rcnt == nbits(CFG.nine_bit) - 4'h1) begin
						n.rxst = (CFG.parity_en || card) ? ST_PAR : ST_STOP;
					end
				end
			end
			ST_PAR: begin
				if (samp) begin
					n.rxst = ST_STOP;
					if (b ^ s.rpar ^ CFG.parity_odd) begin
						fset.par_err = 1'b1;
						n.card_nack = card;
					end
				end
			end
			ST_STOP: begin
				if (samp) begin
					n.card_nack = 1'b0;
					n.rxst = ST_IDLE;
					if (!b && s.rsh == '0) begin
						fset.brk = 1'b1;
						n.lin = 2'h1;
						n.rxst = ST_ACK;
					end else if (!b) begin
						fset.frm_err = 1'b1;
					end else if (s.lin == 2'h1) begin
						fset.sync_err = s.rsh[7:0] != `MPS_LIN_SYNC;
						n.lin = fset.sync_err ? 2'h0 : 2'h2;
					end else begin
						rx_push = 1'b1;
						rx_word = CFG.nine_bit ? s.rsh : {1'b0, s.rsh[7:0]};
						if (s.lin == 2'h2) begin
							rx_word[8] = 1'b1;
						end
						n.lin = 2'h0;
					end
				end
			end
			ST_ACK: begin
				if (b) begin
					n.rxst = ST_IDLE;
				end
			end
			default: n.rxst = ST_IDLE;
		endcase
		// I2C slave, driven by the bus's own edges
		if (i2c_s && s.scl_q && SCL_I && s.sda_q && !SDA_I) begin
			n.sl_act = 1'b1;
			n.sl_addr = 1'b1;
			n.sl_cnt = 4'h0;
			n.sl_oe = 1'b0;
		end else if (i2c_s && s.scl_q && SCL_I && !s.sda_q && SDA_I) begin
			n.sl_act = 1'b0;
			n.sl_oe = 1'b0;
			fset.done = s.sl_act;
		end else if (i2c_s && s.sl_act && !s.scl_q && SCL_I) begin
			n.sl_cnt = s.sl_cnt + 4'h1;
			if (s.sl_cnt < 4'h8) begin
				n.sl_sh = {s.sl_sh[6:0], SDA_I};
			end else if (s.sl_rw && SDA_I) begin
				n.sl_rw = 1'b0;
				n.sl_act = 1'b0;
			end
		end else if (i2c_s && s.sl_act && s.scl_q && !SCL_I) begin
			n.sl_oe = 1'b0;
			if (s.sl_cnt == 4'h8 && s.sl_addr) begin
				n.sl_addr = 1'b0;
				n.sl_rw = s.sl_sh[0];
				n.sl_ptrset = 1'b0;
				n.sl_oe = s.sl_sh[7:1] == CFG.own_addr;
				n.sl_act = n.sl_oe;
			end else if (s.sl_cnt == 4'h8 && !s.sl_rw) begin
				n.sl_oe = 1'b1;
				if (!CFG.mailbox_i2c_mode) begin
					rx_push = 1'b1;
					rx_word = {1'b0, s.sl_sh};
					n.sl_oe = rxq_rdy;
				end else if (!s.sl_ptrset) begin
					n.sl_ptr = s.sl_sh;
					n.sl_ptrset = 1'b1;
				end else begin
					mb_we = 1'b1;
					mb_wd = s.sl_sh;
					n.sl_ptr = ptr_inc(s.sl_ptr);
				end
			end else if (s.sl_cnt == 4'h9) begin
				n.sl_cnt = 4'h0;
				if (s.sl_rw) begin
					if (CFG.mailbox_i2c_mode) begin
						n.sl_sh = mbox[s.sl_ptr[PW-1:0]];
						n.sl_ptr = ptr_inc(s.sl_ptr);
					end else begin
						tx_pop = txq_v;
						n.sl_sh = txq_v ? txq_d[7:0] : 8'hff;
					end
					n.sl_oe = !n.sl_sh[7];
				end
			end else if (s.sl_rw && s.sl_cnt < 4'h8 && s.sl_cnt != 4'h0) begin
				n.sl_oe = !s.sl_sh[7];
			end
		end
		fset.overflow = rx_push && !rxq_rdy;
		// A new event outranks a clear in the same cycle
		n.flags = (s.flags & ~CLR_FLAGS) | fset;
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			s <= '0;
			s.txst <= ST_IDLE;
			s.rxst <= ST_IDLE;
			s.scl_q <= 1'b1;
			s.sda_q <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// Mailbox array; a bus write wins over a CPU write in the same cycle
	always_ff @(posedge CLK) begin
		if (mb_we) begin
			mbox[s.sl_ptr[PW-1:0]] <= mb_wd;
		end else if (MBOX_WE) begin
			mbox[MBOX_ADDR[PW-1:0]] <= MBOX_WDATA;
		end
		if (SRST) begin
			MBOX_RDATA <= 8'h00;
		end else begin
			MBOX_RDATA <= mbox[MBOX_ADDR[PW-1:0]];
		end
	end

	// ****************************************
	// Pins and status
	// ****************************************
	always_comb begin
		case (s.txst)
			ST_DATA: tx_bit = s.tsh[0];
			ST_PAR:  tx_bit = s.tpar ^ CFG.parity_odd;
			ST_START: tx_bit = 1'b0;
			default: tx_bit = 1'b1;
		endcase
	end

	// Smartcard answers a bad parity by pulling the line low
	assign UART_TX = !uart_m ? 1'b1 :
		irda ? (s.txst != ST_IDLE && !tx_bit && s.ph == 2'h0) :
		(tx_bit && !s.card_nack);
	// Open-drain only: the data value is always low
	assign SCL_O  = 1'b0;
	assign SDA_O  = 1'b0;
	assign SCL_OE = i2c_m && s.txst != ST_IDLE && !s.ph[1];
	assign SDA_OE = (i2c_s && s.sl_oe) || (i2c_m && (
		(s.txst == ST_START && s.ph == 2'h3) ||
		(s.txst == ST_DATA && !s.tsh[7]) ||
		(s.txst == ST_STOP && s.ph != 2'h3)));
	assign SPI_SCK = spi_m && s.txst == ST_DATA && s.ph[1];
	assign SPI_SEL = (CFG.sub == `MPS_SUB_SPULSE) ?
		(spi_m && s.txst == ST_START) :
		!(spi_m && (s.txst == ST_START || s.txst == ST_DATA));
	assign SPI_MOSI_O  = s.tsh[7];
	assign SPI_MOSI_OE = spi_m && s.txst == ST_DATA && !(w3 && s.tread);
	assign TX_READY = txq_rdy;
	assign FLAGS    = s.flags;
	assign BUSY     = s.txst != ST_IDLE || s.rxst != ST_IDLE || s.sl_act;
	assign LIN_RATE_ERR = CFG.mode == MPS_MODE_LIN &&
		CFG.clk_div < 16'(`MPS_LIN_MIN_DIV);
	assign IRQ = |(IRQ_EN & {RX_VALID, txq_rdy, s.flags});

endmodule

// >>> verif/mps_unit_sva.sv
// Checker on the ports of one serial unit, bound into it
`timescale 1ns/1ps
`include "mps_params.svh"
module mps_unit_sva import mps_pkg::*; (
	input wire logic       CLK,
	input wire logic       SRST,
	input wire mps_cfg_t   CFG,
	input wire mps_flags_t CLR_FLAGS,
	input wire logic       MBOX_WE,
	input wire logic [7:0] MBOX_ADDR,
	input wire logic [7:0] MBOX_WDATA,
	input wire logic [7:0] MBOX_RDATA,
	input wire logic       RX_VALID,
	input wire logic       RX_READY,
	input wire logic [8:0] RX_DATA,
	input wire logic       UART_TX,
	input wire logic       SCL_O,
	input wire logic       SDA_O,
	input wire logic       SDA_OE,
	input wire logic       SPI_SCK,
	input wire logic       SPI_SEL,
	input wire mps_flags_t FLAGS,
	input wire logic       LIN_RATE_ERR
);
	// ********
	// Properties
	// ********
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);

	// Standard UART on the fastest divider: bit is four cycles
	wire uart_fast = CFG.enable && CFG.mode == MPS_MODE_UART
		&& CFG.sub == `MPS_SUB_STD && CFG.clk_div == 16'h0000;

	property p_od;
		SCL_O == 1'b0 && SDA_O == 1'b0;
	endproperty
	a_od: assert property (p_od)
		else $error("open drain line driven high");
	property p_lin_rate;
		CFG.enable && CFG.mode == MPS_MODE_LIN |->
			LIN_RATE_ERR == (CFG.clk_div < `MPS_LIN_MIN_DIV);
	endproperty
	a_lin_rate: assert property (p_lin_rate)
		else $error("lin rate flag wrong");
	property p_rx_hold;
		RX_VALID && !RX_READY && CFG.enable ##1 CFG.enable |->
			RX_VALID && $stable(RX_DATA);
	endproperty
	a_rx_hold: assert property (p_rx_hold)
		else $error("unread word lost");
	// Flags only fall where cleared
	property p_sticky;
		1'b1 |=> (($past(FLAGS) & ~$past(CLR_FLAGS)) & ~FLAGS) == 8'h00;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("flag fell uncleared");
	property p_start;
		uart_fast && $fell(UART_TX) |-> !UART_TX [*4];
	endproperty
	a_start: assert property (p_start)
		else $error("low bit shorter than four cycles");
	property p_spi_sck;
		CFG.enable && CFG.mode == MPS_MODE_SPI && CFG.sub == `MPS_SUB_STD
			&& SPI_SCK |-> !SPI_SEL;
	endproperty
	a_spi_sck: assert property (p_spi_sck)
		else $error("clock while deselected");
	property p_arb;
		$rose(FLAGS.arb_lost) |-> ##[0:4] !SDA_OE;
	endproperty
	a_arb: assert property (p_arb)
		else $error("data kept after lost arbitration");
	// Read two cycles after a write returns the written byte
	property p_mbox;
		MBOX_WE && CFG.mode != MPS_MODE_I2C ##1 MBOX_ADDR == $past(MBOX_ADDR)
			|=> MBOX_RDATA == $past(MBOX_WDATA, 2);
	endproperty
	a_mbox: assert property (p_mbox)
		else $error("mailbox readback wrong");

	c_arb: cover property ($rose(FLAGS.arb_lost));
	c_nack: cover property ($rose(FLAGS.nack));
	c_lin_id: cover property (CFG.mode == MPS_MODE_LIN && RX_VALID
		&& RX_DATA[8]);
endmodule

bind mps_unit mps_unit_sva mps_unit_sva_i (
	.CLK, .SRST, .CFG, .CLR_FLAGS, .MBOX_WE, .MBOX_ADDR, .MBOX_WDATA,
	.MBOX_RDATA, .RX_VALID, .RX_READY, .RX_DATA, .UART_TX, .SCL_O,
	.SDA_O, .SDA_OE, .SPI_SCK, .SPI_SEL, .FLAGS, .LIN_RATE_ERR
);

// >>> verif/mps_far_end.sv
// Far side: UART loop, pulled-up I2C wires, fixed-answer SPI slave
`timescale 1ns/1ps
module mps_far_end #(
	parameter logic [7:0] PAT = 8'ha5
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic uart_tx,
	input  wire logic force_low,
	output logic      uart_rx,
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	input  wire logic sda_hold,
	output logic      scl_i,
	output logic      sda_i,
	input  wire logic sck,
	input  wire logic sel,
	input  wire logic mosi_o,
	input  wire logic mosi_oe,
	output logic      mosi_i,
	output logic      miso
);
	logic [3:0] cnt;
	logic       sck_q;
	logic       bit_out;

	// Receive follows transmit unless held low as a break
	assign uart_rx = force_low ? 1'b0 : uart_tx;
	// Pull-ups; any low driver wins, rival may hold data
	assign scl_i = !scl_oe;
	assign sda_i = !(sda_oe || sda_hold);
	// Next bit after each fall of the clock, restart while selected off
	always_ff @(posedge clk) begin
		sck_q <= sck;
		if (srst || sel)
			cnt <= 4'h0;
		else if (sck_q && !sck)
			cnt <= cnt + 4'h1;
	end
	// Past eight bits the line no longer holds the pattern
	assign bit_out = cnt[3] ? cnt[0] : PAT[3'h7 - cnt[2:0]];
	assign miso = bit_out;
	assign mosi_i = mosi_oe ? mosi_o : bit_out;
endmodule

// >>> verif/tb.sv
// Self-checking bench for one serial unit against a queue model
`timescale 1ns/1ps
`include "mps_params.svh"
module tb import mps_pkg::*;;
	localparam logic [7:0] PAT = 8'h5a;
	logic       clk, srst, tx_valid, tx_ready, rx_valid, rx_ready, mbox_we;
	logic       force_low, sda_hold, uart_tx, uart_rx, irq, busy;
	logic       scl_i, scl_oe, sda_i, sda_oe, sck, sel;
	logic       mosi_i, mosi_o, mosi_oe, miso, rate_err;
	logic [8:0] tx_data, rx_data;
	logic [7:0] mbox_addr, mbox_wdata, mbox_rdata;
	mps_cfg_t   cfg;
	mps_flags_t clr, flags;
	int         errors, check_count, n;
	int         exp_q[$];

	mps_unit mps_unit_i (
		.CLK(clk), .SRST(srst), .CFG(cfg), .CLR_FLAGS(clr),
		.IRQ_EN(10'h3ff), .TX_VALID(tx_valid), .TX_DATA(tx_data),
		.TX_READY(tx_ready), .RX_VALID(rx_valid), .RX_DATA(rx_data),
		.RX_READY(rx_ready), .MBOX_ADDR(mbox_addr), .MBOX_WE(mbox_we),
		.MBOX_WDATA(mbox_wdata), .MBOX_RDATA(mbox_rdata),
		.UART_RX(uart_rx), .UART_TX(uart_tx), .SCL_I(scl_i), .SCL_O(),
		.SCL_OE(scl_oe), .SDA_I(sda_i), .SDA_O(), .SDA_OE(sda_oe),
		.SPI_SCK(sck), .SPI_SEL(sel), .SPI_MOSI_I(mosi_i),
		.SPI_MOSI_O(mosi_o), .SPI_MOSI_OE(mosi_oe), .SPI_MISO(miso),
		.FLAGS(flags), .BUSY(busy), .LIN_RATE_ERR(rate_err), .IRQ(irq)
	);
	mps_far_end #(.PAT(PAT)) mps_far_end_i (
		.clk(clk), .srst(srst), .uart_tx(uart_tx), .force_low(force_low),
		.uart_rx(uart_rx), .scl_oe(scl_oe), .sda_oe(sda_oe),
		.sda_hold(sda_hold), .scl_i(scl_i), .sda_i(sda_i), .sck(sck),
		.sel(sel), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .mosi_i(mosi_i),
		.miso(miso)
	);

	// ********
	// Helpers
	// ********
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic tally_and_finish();
		if (errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic tmo(int k, int lim);
		if (k >= lim) begin
			chk("wait", 16'h0, 16'h1);
			tally_and_finish();
		end
	endtask
	// Flush with enable low, clear flags, then apply the new setup
	task automatic setup(mps_mode_t m, logic [1:0] s, logic [15:0] d,
		logic nb = 1'b0, logic pe = 1'b0);
		mps_cfg_t c;
		c = '{1'b1, m, s, pe, 1'b0, nb, m == MPS_MODE_I2C, 1'b0, 7'h00, d};
		@(posedge clk);
		cfg.enable <= 1'b0;
		clr <= 8'hff;
		@(posedge clk);
		cfg <= c;
		clr <= 8'h00;
		repeat (8) @(posedge clk);
	endtask
	// Valid stays up after the taking edge; caller lowers it
	task automatic push(logic [8:0] w);
		int k;
		k = 0;
		tx_valid <= 1'b1;
		tx_data <= w;
		do begin
			@(negedge clk);
			k++;
		end while (tx_ready !== 1'b1 && k < 50);
		tmo(k, 50);
		@(posedge clk);
	endtask
	task automatic pop(string nm, int lim);
		int k;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (rx_valid !== 1'b1 && k < lim);
		tmo(k, lim);
		chk(nm, 16'(exp_q.pop_front()), 16'(rx_data));
		@(posedge clk);
		rx_ready <= 1'b1;
		@(posedge clk);
		rx_ready <= 1'b0;
	endtask
	task automatic wflag(int b, int lim);
		int k;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (flags[b] !== 1'b1 && k < lim);
		tmo(k, lim);
		chk("flag", 16'h1, 16'(flags[b]));
	endtask

	// ********
	// Sequence
	// ********
	initial begin
		errors = 0;
		check_count = 0;
		srst = 1'b1;
		cfg = '0;
		clr = '0;
		tx_valid = 1'b0;
		tx_data = '0;
		rx_ready = 1'b0;
		mbox_we = 1'b0;
		mbox_addr = '0;
		mbox_wdata = '0;
		force_low = 1'b0;
		sda_hold = 1'b0;
		n = $urandom(23);
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		// UART loop: std, nine-bit, parity, IrDA, card
		for (int k = 0; k < 5; k++) begin
			setup(MPS_MODE_UART, k > 2 ? 2'(k - 1) : `MPS_SUB_STD, 16'h0000,
				k == 1, k == 2);
			for (int i = 0; i < 6; i++) begin
				n = i == 0 ? 0 : i == 1 ? 'h1ff : $urandom % 'h200;
				if (k != 1)
					n &= 'hff;
				exp_q.push_back(n);
				push(9'(n));
			end
			tx_valid <= 1'b0;
			repeat (6) pop("uart", 400);
			chk("flags", 16'h20, 16'(flags));
			chk("busy", 16'h0, 16'(busy));
		end
		// Line held low past a frame: break, nothing stored
		setup(MPS_MODE_UART, `MPS_SUB_STD, 16'h0000);
		force_low <= 1'b1;
		repeat (48) @(posedge clk);
		force_low <= 1'b0;
		wflag(2, 100);
		repeat (8) @(negedge clk);
		chk("rx_valid", 16'h0, 16'(rx_valid));
		// Slow line: transmit queue refuses once full
		setup(MPS_MODE_UART, `MPS_SUB_STD, 16'h00c8);
		tx_valid <= 1'b1;
		n = 0;
		repeat (12) begin
			@(negedge clk);
			n += tx_ready;
			@(posedge clk);
		end
		tx_valid <= 1'b0;
		chk("fill", 16'h1, 16'(n == 8 || n == 9));
		// SPI: slave answers a fixed byte; last pass is a 3-wire write
		for (int k = 0; k < 4; k++) begin
			setup(MPS_MODE_SPI, k > 1 ? `MPS_SUB_3WIRE : 2'(k), 16'h0000);
			push({k < 3, 8'($urandom)});
			tx_valid <= 1'b0;
			if (k < 3) begin
				exp_q.push_back(PAT);
				pop("spi", 200);
			end
			wflag(5, 200);
			chk("rx_valid", 16'h0, 16'(rx_valid));
		end
		// Mailbox written from the CPU side, read back
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			n = $urandom % 'h100;
			exp_q.push_back(n);
			mbox_we <= 1'b1;
			mbox_addr <= 8'(i * 9);
			mbox_wdata <= 8'(n);
			repeat (2) @(posedge clk);
		end
		mbox_we <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			mbox_addr <= 8'(i * 9);
			@(posedge clk);
			@(negedge clk);
			chk("mbox", 16'(exp_q.pop_front()), 16'(mbox_rdata));
			@(posedge clk);
		end
		// I2C master: nobody answers, then a rival holds data low
		setup(MPS_MODE_I2C, `MPS_SUB_STD, 16'h0000);
		push(9'h1a4);
		tx_valid <= 1'b0;
		wflag(4, 400);
		wflag(5, 400);
		setup(MPS_MODE_I2C, `MPS_SUB_STD, 16'h0000);
		push(9'h1ff);
		tx_valid <= 1'b0;
		repeat (12) @(posedge clk);
		sda_hold <= 1'b1;
		wflag(3, 200);
		repeat (4) @(negedge clk);
		chk("sda_oe", 16'h0, 16'(sda_oe));
		chk("irq", 16'h1, 16'(irq));
		@(posedge clk);
		sda_hold <= 1'b0;
		// LIN slave: rate limit, then break, sync, identifier, data
		setup(MPS_MODE_LIN, `MPS_SUB_STD, 16'(`MPS_LIN_MIN_DIV - 1));
		@(negedge clk);
		chk("rate", 16'h1, 16'(rate_err));
		setup(MPS_MODE_LIN, `MPS_SUB_STD, 16'(`MPS_LIN_MIN_DIV));
		@(negedge clk);
		chk("rate", 16'h0, 16'(rate_err));
		@(posedge clk);
		force_low <= 1'b1;
		repeat (6000) @(posedge clk);
		force_low <= 1'b0;
		repeat (1000) @(posedge clk);
		exp_q.push_back('h13c);
		exp_q.push_back('h0aa);
		push(9'h055);
		push(9'h03c);
		push(9'h0aa);
		tx_valid <= 1'b0;
		pop("lin", 20000);
		pop("lin", 6000);
		tally_and_finish();
	end
endmodule
